// *** logic/lsaas_pkg.sv ***
// Package with register indices, field positions, reset values and thresholds of the line sense block.
package lsaas_pkg;
    localparam int IDX_W = 6;
    localparam int ADDR_W = 8;
    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_FAULT_FLAG = 6'h03;
    localparam logic [5:0] IDX_IRQ_ENABLE = 6'h05;
    localparam logic [5:0] IDX_DET_ENABLE = 6'h12;
    localparam logic [5:0] IDX_OV_THRESH = 6'h13;
    localparam logic [5:0] IDX_DET_CTRL = 6'h15;
    localparam logic [5:0] IDX_LINE_CTRL = 6'h16;
    localparam logic [5:0] IDX_RING_RESULT = 6'h1A;
    localparam logic [5:0] IDX_LINE_V_RESULT = 6'h1B;
    localparam logic [5:0] IDX_LOOP_I_RESULT = 6'h1C;
    localparam logic [5:0] IDX_DET_STATUS = 6'h1E;
    localparam logic [5:0] IDX_EVT_STATUS = 6'h20;
    localparam logic [5:0] IDX_EVT_MASK = 6'h21;
    // Field positions.
    localparam int BIT_FAULT_FLAG = 2;
    localparam int BIT_IRQ_ENABLE = 2;
    localparam int BIT_DET_ENABLE = 1;
    localparam int BIT_OV_THRESH = 2;
    localparam int BIT_OC_EN = 0;
    localparam int BIT_OV_EN = 1;
    localparam int BIT_UV_EN = 2;
    localparam int BIT_NOM_BW = 0;
    localparam int BIT_OV_GATE = 1;
    localparam int BIT_I_LIMIT = 2;
    localparam int BIT_OC_STATUS = 4;
    localparam int BIT_OV_STATUS = 5;
    localparam int BIT_UV_STATUS = 6;
    // Reset values.
    localparam logic [2:0] RST_DET_CTRL = 3'h0;
    localparam logic [2:0] RST_LINE_CTRL = 3'h0;
    localparam logic [2:0] RST_EVT_MASK = 3'h0;
    // Loop current scale and over-current limits.
    localparam int LOOP_I_LSB_UA = 1250;
    localparam int OC_LIMIT_HIGH_MA = 125;
    localparam int OC_LIMIT_LOW_MA = 55;
    localparam logic [6:0] OC_COUNT_HIGH = 7'(OC_LIMIT_HIGH_MA * 1000 / LOOP_I_LSB_UA);
    localparam logic [6:0] OC_COUNT_LOW = 7'(OC_LIMIT_LOW_MA * 1000 / LOOP_I_LSB_UA);
    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lsaas_pkg

// *** logic/lsaas_reg_if.sv ***
// Interface carrying register access strobes from the bus slave to the register file.
`timescale 1ns/10ps
`default_nettype none
interface lsaas_reg_if;
    logic        wr_en;
    logic [5:0]  wr_idx;
    logic [7:0]  wr_data;
    logic        wr_err;
    logic        rd_en;
    logic [5:0]  rd_idx;
    logic [31:0] rd_data;
    logic        rd_err;
    // Bus side issues strobes and receives decode answers.
    modport bus (output wr_en, wr_idx, wr_data, rd_en, rd_idx,
                 input wr_err, rd_data, rd_err);
    // Register side decodes and answers.
    modport regs (input wr_en, wr_idx, wr_data, rd_en, rd_idx,
                  output wr_err, rd_data, rd_err);
endinterface : lsaas_reg_if
`default_nettype wire

// *** logic/lsaas_axil_slave.sv ***
// AXI4-Lite slave that turns bus transfers into register strobes.
`timescale 1ns/10ps
`default_nettype none
module lsaas_axil_slave (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    lsaas_reg_if.bus         rif
);
    logic       aw_held;
    logic       w_held;
    logic [5:0] aw_idx;
    logic [7:0] w_byte;
    logic       w_lane0;
    logic       pair_ready;

    // Address and data are held separately so they may arrive in either order.
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign pair_ready = aw_held && w_held && !bvalid;
    assign rif.wr_en = pair_ready && w_lane0;
    assign rif.wr_idx = aw_idx;
    assign rif.wr_data = w_byte;
    // Reads sample the register side in the handshake cycle, so rdata stays coherent.
    assign arready = !rvalid;
    assign rif.rd_en = arvalid && arready;
    assign rif.rd_idx = araddr[7:2];

    // Write channel holding registers and response.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 6'h00;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            bvalid <= 1'b0;
            bresp <= lsaas_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_idx <= awaddr[7:2];
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_byte <= wdata[7:0];
                w_lane0 <= wstrb[0];
            end
            if (pair_ready) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= rif.wr_err ? lsaas_pkg::RESP_SLVERR : lsaas_pkg::RESP_OKAY;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Read response register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= lsaas_pkg::RESP_OKAY;
        end else if (rif.rd_en) begin
            rvalid <= 1'b1;
            rdata <= rif.rd_data;
            rresp <= rif.rd_err ? lsaas_pkg::RESP_SLVERR : lsaas_pkg::RESP_OKAY;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule : lsaas_axil_slave
`default_nettype wire

// *** logic/lsaas_detect.sv ***
// Under-voltage, over-voltage and over-current detectors with bandwidth override.
`timescale 1ns/10ps
`default_nettype none
module lsaas_detect (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       det_enable,
    input  wire logic       uv_enable,
    input  wire logic       ov_enable,
    input  wire logic       oc_enable,
    input  wire logic       ov_thresh_sel,
    input  wire logic       nominal_bw_ctrl,
    input  wire logic       ov_gate_enable,
    input  wire logic       current_limit_mode,
    input  wire logic       line_supply_undervolt,
    input  wire logic       ring_over_low_thr,
    input  wire logic       ring_over_high_thr,
    input  wire logic [6:0] loop_current,
    output logic            uv_status,
    output logic            ov_status,
    output logic            oc_status,
    output logic            nominal_bw_effective
);
    logic       uv_now;
    logic       nom_now;
    logic       ov_cmp;
    logic       ov_now;
    logic [6:0] oc_limit;
    logic       oc_now;

    // All three detectors are gated by the common line-side enable.
    assign uv_now = det_enable && uv_enable && line_supply_undervolt;
    assign nom_now = nominal_bw_ctrl && !uv_now;
    assign ov_cmp = ov_thresh_sel ? ring_over_high_thr : ring_over_low_thr;
    assign ov_now = det_enable && ov_enable && ov_gate_enable && nom_now && ov_cmp;
    assign oc_limit = current_limit_mode ? lsaas_pkg::OC_COUNT_LOW : lsaas_pkg::OC_COUNT_HIGH;
    assign oc_now = det_enable && oc_enable && (loop_current > oc_limit);

    // Status levels follow the conditions one cycle later; they are not latched.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            uv_status <= 1'b0;
            ov_status <= 1'b0;
            oc_status <= 1'b0;
            nominal_bw_effective <= 1'b0;
        end else begin
            uv_status <= uv_now;
            ov_status <= ov_now;
            oc_status <= oc_now;
            nominal_bw_effective <= nom_now;
        end
    end
endmodule : lsaas_detect
`default_nettype wire

// *** logic/lsaas_top.sv ***
// Top of the line sense block: register file, result latches, fault flag and interrupt.
`timescale 1ns/10ps
`default_nettype none
module lsaas_top (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        aux_conv_valid,
    input  wire logic [7:0]  aux_ring_code,
    input  wire logic [6:0]  aux_dc_code_msbs,
    input  wire logic [6:0]  aux_current_code,
    input  wire logic        line_supply_undervolt,
    input  wire logic        ring_over_low_thr,
    input  wire logic        ring_over_high_thr,
    output logic             nominal_bw_effective,
    output logic             irq
);
    lsaas_reg_if rif ();

    logic       line_fault_flag;
    logic       line_fault_irq_enable;
    logic       line_side_detectors_enable;
    logic       overvolt_threshold_select;
    logic [2:0] det_ctrl;
    logic [2:0] line_ctrl;
    logic [7:0] ring_voltage_result;
    logic [6:0] line_voltage_result;
    logic [6:0] loop_current_result;
    logic [2:0] evt_status;
    logic [2:0] evt_mask;
    logic       undervolt_status;
    logic       overvolt_status;
    logic       overcurrent_status;
    logic [2:0] det_status;
    logic       any_condition;
    logic       wr_irq_enable;
    logic       wr_det_enable;
    logic       wr_ov_thresh;
    logic       wr_det_ctrl;
    logic       wr_line_ctrl;
    logic       wr_evt_status;
    logic       wr_evt_mask;
    logic       rd_fault_flag;
    logic       wr_mapped;
    logic       rd_mapped;
    logic [7:0] rd_byte;
    logic [2:0] next_evt_status;
    logic       next_fault_flag;

    // Bus slave; it only moves strobes, all decoding lives here.
    lsaas_axil_slave u_axil (
        .clk     (clk),
        .rst_n   (rst_n),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .rif     (rif)
    );

    // Detector unit driven by the software controls.
    lsaas_detect u_detect (
        .clk                   (clk),
        .rst_n                 (rst_n),
        .det_enable            (line_side_detectors_enable),
        .uv_enable             (det_ctrl[lsaas_pkg::BIT_UV_EN]),
        .ov_enable             (det_ctrl[lsaas_pkg::BIT_OV_EN]),
        .oc_enable             (det_ctrl[lsaas_pkg::BIT_OC_EN]),
        .ov_thresh_sel         (overvolt_threshold_select),
        .nominal_bw_ctrl       (line_ctrl[lsaas_pkg::BIT_NOM_BW]),
        .ov_gate_enable        (line_ctrl[lsaas_pkg::BIT_OV_GATE]),
        .current_limit_mode    (line_ctrl[lsaas_pkg::BIT_I_LIMIT]),
        .line_supply_undervolt (line_supply_undervolt),
        .ring_over_low_thr     (ring_over_low_thr),
        .ring_over_high_thr    (ring_over_high_thr),
        .loop_current          (loop_current_result),
        .uv_status             (undervolt_status),
        .ov_status             (overvolt_status),
        .oc_status             (overcurrent_status),
        .nominal_bw_effective  (nominal_bw_effective)
    );

    // Write decode; every register takes its bits from the low byte.
    assign wr_irq_enable = rif.wr_en && (rif.wr_idx == lsaas_pkg::IDX_IRQ_ENABLE);
    assign wr_det_enable = rif.wr_en && (rif.wr_idx == lsaas_pkg::IDX_DET_ENABLE);
    assign wr_ov_thresh = rif.wr_en && (rif.wr_idx == lsaas_pkg::IDX_OV_THRESH);
    assign wr_det_ctrl = rif.wr_en && (rif.wr_idx == lsaas_pkg::IDX_DET_CTRL);
    assign wr_line_ctrl = rif.wr_en && (rif.wr_idx == lsaas_pkg::IDX_LINE_CTRL);
    assign wr_evt_status = rif.wr_en && (rif.wr_idx == lsaas_pkg::IDX_EVT_STATUS);
    assign wr_evt_mask = rif.wr_en && (rif.wr_idx == lsaas_pkg::IDX_EVT_MASK);
    // Read-only registers and unknown indices answer a write with an error.
    assign wr_mapped = (rif.wr_idx == lsaas_pkg::IDX_IRQ_ENABLE) ||
                       (rif.wr_idx == lsaas_pkg::IDX_DET_ENABLE) ||
                       (rif.wr_idx == lsaas_pkg::IDX_OV_THRESH) ||
                       (rif.wr_idx == lsaas_pkg::IDX_DET_CTRL) ||
                       (rif.wr_idx == lsaas_pkg::IDX_LINE_CTRL) ||
                       (rif.wr_idx == lsaas_pkg::IDX_EVT_STATUS) ||
                       (rif.wr_idx == lsaas_pkg::IDX_EVT_MASK);
    assign rif.wr_err = !wr_mapped;

    // Software control registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_fault_irq_enable <= 1'b0;
            line_side_detectors_enable <= 1'b0;
            overvolt_threshold_select <= 1'b0;
            det_ctrl <= lsaas_pkg::RST_DET_CTRL;
            line_ctrl <= lsaas_pkg::RST_LINE_CTRL;
            evt_mask <= lsaas_pkg::RST_EVT_MASK;
        end else begin
            if (wr_irq_enable) begin
                line_fault_irq_enable <= rif.wr_data[lsaas_pkg::BIT_IRQ_ENABLE];
            end
            if (wr_det_enable) begin
                line_side_detectors_enable <= rif.wr_data[lsaas_pkg::BIT_DET_ENABLE];
            end
            if (wr_ov_thresh) begin
                overvolt_threshold_select <= rif.wr_data[lsaas_pkg::BIT_OV_THRESH];
            end
            if (wr_det_ctrl) begin
                det_ctrl <= rif.wr_data[2:0];
            end
            if (wr_line_ctrl) begin
                line_ctrl <= rif.wr_data[2:0];
            end
            if (wr_evt_mask) begin
                evt_mask <= rif.wr_data[2:0];
            end
        end
    end

    // Converter results are captured on the converter's strobe and held between samples.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ring_voltage_result <= 8'h00;
            line_voltage_result <= 7'h00;
            loop_current_result <= 7'h00;
        end else if (aux_conv_valid) begin
            ring_voltage_result <= aux_ring_code;
            line_voltage_result <= aux_dc_code_msbs;
            loop_current_result <= aux_current_code;
        end
    end

    // Fault flag: a condition present in the clearing read's cycle keeps the flag set.
    assign det_status = {undervolt_status, overvolt_status, overcurrent_status};
    assign any_condition = |det_status;
    assign rd_fault_flag = rif.rd_en && (rif.rd_idx == lsaas_pkg::IDX_FAULT_FLAG);
    assign next_fault_flag = any_condition || (line_fault_flag && !rd_fault_flag);
    // Per-cause sticky bits cleared by writing one; a new event wins over the clear.
    assign next_evt_status = det_status |
                             (evt_status & ~(wr_evt_status ? rif.wr_data[2:0] : 3'h0));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_fault_flag <= 1'b0;
            evt_status <= 3'h0;
        end else begin
            line_fault_flag <= next_fault_flag;
            evt_status <= next_evt_status;
        end
    end

    // One level interrupt; the fault path drops as soon as a read clears the flag.
    assign irq = (line_fault_flag && line_fault_irq_enable) || (|(evt_status & evt_mask));

    // Read mux; write-only controls read back so software can verify them.
    always_comb begin
        rd_byte = 8'h00;
        rd_mapped = 1'b1;
        case (rif.rd_idx)
            lsaas_pkg::IDX_FAULT_FLAG: rd_byte[lsaas_pkg::BIT_FAULT_FLAG] = line_fault_flag;
            lsaas_pkg::IDX_IRQ_ENABLE: rd_byte[lsaas_pkg::BIT_IRQ_ENABLE] = line_fault_irq_enable;
            lsaas_pkg::IDX_DET_ENABLE: begin
                rd_byte[lsaas_pkg::BIT_DET_ENABLE] = line_side_detectors_enable;
            end
            lsaas_pkg::IDX_OV_THRESH: begin
                rd_byte[lsaas_pkg::BIT_OV_THRESH] = overvolt_threshold_select;
            end
            lsaas_pkg::IDX_DET_CTRL: rd_byte[2:0] = det_ctrl;
            lsaas_pkg::IDX_LINE_CTRL: rd_byte[2:0] = line_ctrl;
            lsaas_pkg::IDX_RING_RESULT: rd_byte = ring_voltage_result;
            lsaas_pkg::IDX_LINE_V_RESULT: rd_byte = {line_voltage_result, 1'b0};
            lsaas_pkg::IDX_LOOP_I_RESULT: rd_byte = {loop_current_result, 1'b0};
            lsaas_pkg::IDX_DET_STATUS: begin
                rd_byte[lsaas_pkg::BIT_UV_STATUS] = undervolt_status;
                rd_byte[lsaas_pkg::BIT_OV_STATUS] = overvolt_status;
                rd_byte[lsaas_pkg::BIT_OC_STATUS] = overcurrent_status;
            end
            lsaas_pkg::IDX_EVT_STATUS: rd_byte[2:0] = evt_status;
            lsaas_pkg::IDX_EVT_MASK: rd_byte[2:0] = evt_mask;
            default: rd_mapped = 1'b0;
        endcase
    end

    assign rif.rd_data = {24'h00_0000, rd_byte};
    assign rif.rd_err = !rd_mapped;

    // Checks on the block's own behaviour.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_RING_CAPTURE: assert property (
        aux_conv_valid |=> ring_voltage_result == $past(aux_ring_code))
        else $error("Ring result did not capture the converter code.");

    AST_LINE_V_READ: assert property (
        rif.rd_en && rif.rd_idx == lsaas_pkg::IDX_LINE_V_RESULT
        |=> s_axi_rdata[7:0] == {$past(line_voltage_result), 1'b0})
        else $error("Line voltage read did not return bits 7 to 1.");

    AST_LOOP_I_CAPTURE: assert property (
        aux_conv_valid |=> loop_current_result == $past(aux_current_code))
        else $error("Loop current result did not capture the converter code.");

    AST_FLAG_SET: assert property (
        any_condition |=> line_fault_flag)
        else $error("Fault flag not set after a detected condition.");

    AST_FLAG_CLEAR: assert property (
        rd_fault_flag && !any_condition |=> !line_fault_flag)
        else $error("Fault flag not cleared by its read.");

    AST_IRQ_MASKED: assert property (
        !line_fault_irq_enable && (evt_status & evt_mask) == 3'h0 |-> !irq)
        else $error("Interrupt raised with the fault enable off.");

    AST_DET_IGNORED: assert property (
        !line_side_detectors_enable |=> det_status == 3'h0)
        else $error("Detector status seen while detectors disabled.");

    AST_WIDE_BW: assert property (
        undervolt_status |-> !nominal_bw_effective)
        else $error("Bandwidth not forced wide during under-voltage.");

    AST_UV_FOLLOW: assert property (
        line_side_detectors_enable && det_ctrl[lsaas_pkg::BIT_UV_EN] && line_supply_undervolt
        |=> undervolt_status)
        else $error("Under-voltage status missed the supply condition.");

    AST_OV_GATED: assert property (
        overvolt_status |-> $past(det_ctrl[lsaas_pkg::BIT_OV_EN]
                                  && line_ctrl[lsaas_pkg::BIT_OV_GATE]
                                  && line_ctrl[lsaas_pkg::BIT_NOM_BW]))
        else $error("Over-voltage reported without all of its enables.");

    AST_OC_OFF: assert property (
        !det_ctrl[lsaas_pkg::BIT_OC_EN] |=> !overcurrent_status)
        else $error("Over-current reported while its detector is off.");

    AST_OC_LIMIT: assert property (
        !line_ctrl[lsaas_pkg::BIT_I_LIMIT] && loop_current_result <= lsaas_pkg::OC_COUNT_HIGH
        |=> !overcurrent_status)
        else $error("Over-current reported at or below 125 mA.");

    AST_IRQ_HOLD: assert property (
        (line_fault_irq_enable && any_condition && !wr_irq_enable)
        ##1 (!rd_fault_flag && !wr_irq_enable) |-> irq [*2])
        else $error("Interrupt dropped while flag and enable held.");

    // The drop is checked only with the event path quiet, since that path shares the pin.
    AST_IRQ_DROP: assert property (
        rd_fault_flag && !any_condition && (evt_status & evt_mask) == 3'h0 && !wr_evt_mask
        |=> !irq)
        else $error("Interrupt stayed high after the fault flag was cleared.");

    AST_ENABLE_WRITE: assert property (
        wr_irq_enable
        |=> line_fault_irq_enable == $past(rif.wr_data[lsaas_pkg::BIT_IRQ_ENABLE]))
        else $error("Fault interrupt enable did not take the written bit.");

    AST_RING_READ: assert property (
        rif.rd_en && rif.rd_idx == lsaas_pkg::IDX_RING_RESULT
        |=> s_axi_rdata[7:0] == $past(ring_voltage_result))
        else $error("Ring voltage read did not return the held result.");

    AST_LOOP_I_READ: assert property (
        rif.rd_en && rif.rd_idx == lsaas_pkg::IDX_LOOP_I_RESULT
        |=> s_axi_rdata[7:0] == {$past(loop_current_result), 1'b0})
        else $error("Loop current read did not return bits 7 to 1.");

    AST_FLAG_READ: assert property (
        rd_fault_flag |=> s_axi_rdata[lsaas_pkg::BIT_FAULT_FLAG] == $past(line_fault_flag))
        else $error("Fault flag read did not return the value before the clear.");

    AST_UV_OFF: assert property (
        !line_supply_undervolt |=> !undervolt_status)
        else $error("Under-voltage status shown without the supply condition.");

    AST_OV_LOW_THR: assert property (
        !overvolt_threshold_select && !ring_over_low_thr |=> !overvolt_status)
        else $error("Over-voltage reported below the lower threshold.");

    AST_OV_HIGH_THR: assert property (
        overvolt_threshold_select && !ring_over_high_thr |=> !overvolt_status)
        else $error("Over-voltage reported below the higher threshold.");

    AST_OC_LOW_LIMIT: assert property (
        line_ctrl[lsaas_pkg::BIT_I_LIMIT] && loop_current_result <= lsaas_pkg::OC_COUNT_LOW
        |=> !overcurrent_status)
        else $error("Over-current reported at or below 55 mA in limit mode.");

    AST_OC_SET: assert property (
        line_side_detectors_enable && det_ctrl[lsaas_pkg::BIT_OC_EN]
        && loop_current_result > lsaas_pkg::OC_COUNT_HIGH |=> overcurrent_status)
        else $error("Over-current not reported above 125 mA.");
endmodule : lsaas_top
`default_nettype wire

// *** testbench/lsaas_line_model.sv ***
// Line-side converter model: a conversion strobe every eighth cycle.
`timescale 1ns/10ps
`default_nettype none
module lsaas_line_model (
    input  wire logic       clk,
    input  wire logic [6:0] cur,
    output logic            conv,
    output logic [7:0]      ring_q,
    output logic [6:0]      cur_q
);
    logic [2:0] cnt = 3'h0;
    // Codes are good only with the strobe; the inverse shows otherwise, so late capture shows.
    always @(posedge clk) cnt <= cnt + 3'h1;
    assign conv = (cnt == 3'h7);
    assign ring_q = conv ? 8'hA5 : 8'h5A;
    assign cur_q = conv ? cur : ~cur;
endmodule : lsaas_line_model
`default_nettype wire

// *** testbench/test_lsaas_top.sv ***
// Table-driven bench for the line sense block over its register bus.
`timescale 1ns/10ps
`default_nettype none
module test_lsaas_top;
    logic        clk, rst_n, awv, wv, bry, arv, rry, uv, ovl, ovh, cv, aw_r, w_r, bv, ar_r, rv;
    logic        nbw, irq;
    logic [7:0]  awa, ara, rq;
    logic [6:0]  cur, iq;
    logic [31:0] wd, rdata;
    logic [1:0]  bresp, rresp;
    int          failures = 0;
    int          compares = 0;
    // Steps: op, index, data. Ops: 0 write, 1 read, 2 pins, 3 current, 4 outputs, 6 unmapped.
    logic [19:0] stp [$] = '{20'h1_03_00, 20'h1_05_00, 20'h1_15_00, 20'h1_1E_00,
        20'h6_3F_00, 20'h4_00_00, 20'h7_00_01, 20'h1_1A_A5, 20'h1_1B_A4,
        20'h1_1C_06, 20'h7_00_02, 20'h0_15_07, 20'h0_16_01, 20'h2_00_04,
        20'h1_1E_00, 20'h1_03_00, 20'h4_00_02, 20'h7_00_03, 20'h0_12_02,
        20'h1_1E_40, 20'h4_00_00, 20'h0_05_04, 20'h4_00_01, 20'h2_00_00,
        20'h4_00_03, 20'h1_03_04, 20'h1_03_00, 20'h4_00_02, 20'h7_00_04,
        20'h0_16_05, 20'h3_00_2D, 20'h1_1E_10, 20'h3_00_2C, 20'h1_1E_00,
        20'h0_16_01, 20'h3_00_65, 20'h1_1E_10, 20'h3_00_64, 20'h1_1E_00,
        20'h3_00_65, 20'h0_15_06, 20'h1_1E_00, 20'h1_03_04, 20'h4_00_02,
        20'h0_21_01, 20'h4_00_03, 20'h0_20_01, 20'h4_00_02, 20'h7_00_05,
        20'h0_16_03, 20'h2_00_02, 20'h1_1E_20, 20'h0_13_04, 20'h1_1E_00,
        20'h2_00_03, 20'h1_1E_20, 20'h0_16_01, 20'h1_1E_00, 20'h7_00_06};
    lsaas_top lsaas_top_i (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(aw_r), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(w_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(ar_r), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry), .aux_conv_valid(cv),
        .aux_ring_code(rq), .aux_dc_code_msbs(rq[7:1]), .aux_current_code(iq),
        .line_supply_undervolt(uv), .ring_over_low_thr(ovl), .ring_over_high_thr(ovh),
        .nominal_bw_effective(nbw), .irq(irq));
    lsaas_line_model lsaas_line_model_i (.clk(clk), .cur(cur), .conv(cv), .ring_q(rq), .cur_q(iq));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) failures++;
        if (s !== e) $display("wrong value at %0t: saw %h, expected %h", $time, s, e);
    endtask : chk
    // Address and data are offered together and each is dropped at its own handshake.
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        {awa, wd, awv, wv, bry} <= {i, 2'h0, 24'h0, d, 3'h7};
        do begin
            @(posedge clk);
            {awv, wv} <= {awv && !aw_r, wv && !w_r};
            #1;
        end while (awv || wv);
        do @(posedge clk); while (!bv);
        chk({30'h0, bresp}, 32'h0);
        bry <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rc(input logic [5:0] i, input logic [31:0] e, input logic [1:0] r);
        {ara, arv, rry} <= {i, 2'h0, 2'h3};
        do @(posedge clk); while (!ar_r);
        arv <= 1'b0;
        do @(posedge clk); while (!rv);
        chk(rdata, e);
        chk({30'h0, rresp}, {30'h0, r});
        rry <= 1'b0;
        @(posedge clk);
    endtask : rc
    task automatic finish_test;
        $display("compares %0d, failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    // The table needs under two thousand cycles; this guard allows far more.
    initial begin
        #400000 failures++;
        finish_test();
    end
    initial begin
        {rst_n, awv, wv, bry, arv, rry, uv, ovl, ovh, awa, ara, wd} = '0;
        cur = 7'h03;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (stp[k]) begin
            case (stp[k][19:16])
                4'h0: wr(stp[k][13:8], stp[k][7:0]);
                4'h1: rc(stp[k][13:8], {24'h0, stp[k][7:0]}, 2'h0);
                4'h2: {uv, ovl, ovh} <= stp[k][2:0];
                4'h3: cur <= stp[k][6:0];
                4'h4: chk({30'h0, nbw, irq}, {30'h0, stp[k][1:0]});
                4'h6: rc(stp[k][13:8], 32'h0, 2'h2);
                default: $display("test %0d done", stp[k][7:0]);
            endcase
            if (stp[k][19:17] == 3'h1) repeat (12) @(posedge clk);
        end
        finish_test();
    end
endmodule : test_lsaas_top
`default_nettype wire
